// [hw/zone_defines.svh]
`ifndef ZONE_DEFINES_SVH
`define ZONE_DEFINES_SVH
// Notes on behaviour
// - every input current channel carries its own connection-status bit.
// - the zone is one list of channel/status pairs; only one zone exists.
// - ratio mismatch up to 32:1 is accepted, rescaling is done inside.
// - one per-unit equals the largest rated primary of the zone's CTs.
// - the base is fixed at configuration, whatever the status bits do.
// - per-unit differential depends only on total primary current.
// - a minimum differential threshold blocks operation at light load.
// - below the lower knee the boundary is the low slope times restraint.
// - above the upper knee the boundary is the high slope through origin.
// - between knees a cubic spline joins the two slopes without a step.
// - differential is the per-unit phasor sum of connected inputs only.
// - restraint is the largest per-unit magnitude of connected inputs.

`define N_CH           6
`define MAG_W          24
`define SCALE_W        17
`define FRAC_SHIFT     12
`define SLOPE_SHIFT    8
`define QUO_TO_T       4
`define MISMATCH_SHIFT 5
`define DIV_LAST       5'h10
`define ONE_PU_SCALE   17'h10000
`define PU_ONE         64'sh1000

`define A_CTRL         8'h00
`define A_STATUS       8'h04
`define A_MIN_DIFF_THRESHOLD       8'h08
`define A_SLOPE_LO     8'h0C
`define A_SLOPE_HI     8'h10
`define A_KNEE_LO      8'h14
`define A_KNEE_HI      8'h18
`define A_BASE         8'h1C
`define A_DIFF         8'h20
`define A_REST         8'h24
`define A_CHAN_PAGE    3'h2

`define CTRL_APPLY     0
`define CTRL_OVR_CLR   1

`define RST_MIN_DIFF_THRESHOLD     24'h000333
`define RST_SLOPE_LO   8'h40
`define RST_SLOPE_HI   8'h9A
`define RST_KNEE_LO    24'h002000
`define RST_KNEE_HI    24'h008000
`endif

// [hw/zone_pkg.sv]
`include "zone_defines.svh"
package zone_pkg;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0001,
    S_CFG    = 4'b0010,
    S_EVAL   = 4'b0100,
    S_SPLINE = 4'b1000
  } fsm_t;

  typedef struct packed {
    fsm_t                                     fsm;
    logic                                     cfg_req;
    logic                                     cfg_valid;
    logic                                     cfg_error;
    logic                                     overrun;
    logic [2:0]                               idx;
    logic [15:0]                              base;
    logic [`N_CH-1:0][15:0]                   primary;
    logic [`N_CH-1:0][2:0]                    sec;
    logic [`N_CH-1:0][`SCALE_W-1:0]           scale;
    logic [`MAG_W-1:0]                        min_diff_threshold;
    logic [`MAG_W-1:0]                        knee_lo;
    logic [`MAG_W-1:0]                        knee_hi;
    logic [7:0]                               slope_lo;
    logic [7:0]                               slope_hi;
    logic [`MAG_W-1:0]                        diff_re;
    logic [`MAG_W-1:0]                        diff_im;
    logic [`MAG_W-1:0]                        diff_mag;
    logic [`MAG_W-1:0]                        restraint;
    logic [1:0]                               region;
    logic                                     div_start;
    logic                                     flag;
    logic                                     result_valid;
    logic [31:0]                              rd_data;
  } zone_st_t;

  typedef struct packed {
    logic                 busy;
    logic                 done;
    logic [4:0]           step;
    logic [`MAG_W:0]      rem;
    logic [`MAG_W-1:0]    den;
    logic [`SCALE_W-1:0]  quo;
  } div_st_t;

endpackage

// [hw/zone_ratio_divider.sv]
`timescale 1ns/10ps
`include "zone_defines.svh"
// fractional divider: quo = numer * 2^16 / denom, numer not above denom
module zone_ratio_divider (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                start,
  input  wire logic [`MAG_W-1:0]   numer,
  input  wire logic [`MAG_W-1:0]   denom,
  output logic      [`SCALE_W-1:0] quo,
  output logic                     done
);

  zone_pkg::div_st_t st;
  zone_pkg::div_st_t next_st;
  logic [`MAG_W:0]   trial;
  logic              ge;

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    ge = st.rem >= {1'b0, st.den};
    trial = ge ? st.rem - {1'b0, st.den} : st.rem;
    if (start)
    begin
      next_st.busy = 1'b1;
      next_st.rem = {1'b0, numer};
      next_st.den = denom;
      next_st.step = `DIV_LAST;
      next_st.quo = '0;
    end
    else if (st.busy)
    begin
      next_st.quo = {st.quo[`SCALE_W-2:0], ge};
      next_st.rem = {trial[`MAG_W-1:0], 1'b0};
      if (st.step == 5'h00)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
      else
      begin
        next_st.step = st.step - 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign quo = st.quo;
  assign done = st.done;

endmodule

// [hw/bus_zone_ratio_bias_logic.sv]
`timescale 1ns/10ps
`include "zone_defines.svh"
module bus_zone_ratio_bias_logic (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [7:0]                    addr,
  input  wire logic [31:0]                   wr_data,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  output logic      [31:0]                   rd_data,
  input  wire logic                          sample_valid,
  input  wire logic [`N_CH-1:0][15:0]        ch_re,
  input  wire logic [`N_CH-1:0][15:0]        ch_im,
  input  wire logic [`N_CH-1:0]              ch_status,
  output logic                               result_valid,
  output logic                               biased_diff_flag,
  output logic [`MAG_W-1:0]                  diff_mag,
  output logic [`MAG_W-1:0]                  restraint_mag,
  output logic                               cfg_ready
);

  localparam zone_pkg::zone_st_t ZONE_RST = '{
    fsm:      zone_pkg::S_IDLE,
    min_diff_threshold:   `RST_MIN_DIFF_THRESHOLD,
    knee_lo:  `RST_KNEE_LO,
    knee_hi:  `RST_KNEE_HI,
    slope_lo: `RST_SLOPE_LO,
    slope_hi: `RST_SLOPE_HI,
    default:  '0
  };

  zone_pkg::zone_st_t                st;
  zone_pkg::zone_st_t                next_st;
  logic signed [`MAG_W-1:0]          sc_re [`N_CH];
  logic signed [`MAG_W-1:0]          sc_im [`N_CH];
  logic [`MAG_W-1:0]                 sc_mag [`N_CH];
  logic signed [`MAG_W-1:0]          sum_re;
  logic signed [`MAG_W-1:0]          sum_im;
  logic [`MAG_W-1:0]                 max_mag;
  logic [15:0]                       base_max;
  logic                              ratio_err;
  logic [`MAG_W-1:0]                 dm;
  logic [`MAG_W-1:0]                 bnd;
  logic [31:0]                       rd_val;
  logic [`MAG_W-1:0]                 dv_num;
  logic [`MAG_W-1:0]                 dv_den;
  logic [`SCALE_W-1:0]               dv_quo;
  logic                              dv_done;
  logic                              chan_hit;
  logic [2:0]                        chan_idx;

  // magnitude estimate: max(M, 7/8 M + 1/2 m), within about 3 percent
  function automatic logic [`MAG_W-1:0] mag_fn(
    input logic signed [`MAG_W-1:0] a,
    input logic signed [`MAG_W-1:0] b
  );
    logic [`MAG_W:0] ax;
    logic [`MAG_W:0] bx;
    logic [`MAG_W:0] hi;
    logic [`MAG_W:0] lo;
    logic [`MAG_W:0] est;
    ax = a[`MAG_W-1] ? (`MAG_W+1)'(-a) : (`MAG_W+1)'(a);
    bx = b[`MAG_W-1] ? (`MAG_W+1)'(-b) : (`MAG_W+1)'(b);
    hi = (ax > bx) ? ax : bx;
    lo = (ax > bx) ? bx : ax;
    est = hi - (hi >> 3) + (lo >> 1);
    if (est < hi)
      est = hi;
    return est[`MAG_W] ? '1 : est[`MAG_W-1:0];
  endfunction

  // constant percentage bias: r times slope (slope in 1/256 steps)
  function automatic logic [`MAG_W-1:0] bias_fn(
    input logic [`MAG_W-1:0] r,
    input logic [7:0]        s
  );
    logic [31:0] prod;
    prod = 32'(r) * 32'(s);
    return prod[`MAG_W-1+`SLOPE_SHIFT:`SLOPE_SHIFT];
  endfunction

  // hermite cubic from (k1, s1*k1) slope s1 to (k2, s2*k2) slope s2
  function automatic logic [`MAG_W-1:0] spline_fn(
    input logic [12:0]       t,
    input logic [`MAG_W-1:0] k1,
    input logic [`MAG_W-1:0] k2,
    input logic [7:0]        s1,
    input logic [7:0]        s2
  );
    logic signed [63:0] tt;
    logic signed [63:0] t2;
    logic signed [63:0] t3;
    logic signed [63:0] h00;
    logic signed [63:0] h01;
    logic signed [63:0] h10;
    logic signed [63:0] h11;
    logic signed [63:0] y0;
    logic signed [63:0] y1;
    logic signed [63:0] span;
    logic signed [63:0] acc;
    tt = {51'h0, t};
    t2 = (tt * tt) >>> `FRAC_SHIFT;
    t3 = (t2 * tt) >>> `FRAC_SHIFT;
    h00 = (t3 <<< 1) - (t2 <<< 1) - t2 + `PU_ONE;
    h01 = (t2 <<< 1) + t2 - (t3 <<< 1);
    h10 = t3 - (t2 <<< 1) + tt;
    h11 = t3 - t2;
    y0 = {40'h0, bias_fn(k1, s1)};
    y1 = {40'h0, bias_fn(k2, s2)};
    span = {40'h0, k2} - {40'h0, k1};
    acc = y0 * h00 + y1 * h01;
    acc = acc + ((span * ($signed({56'h0, s1}) * h10
          + $signed({56'h0, s2}) * h11)) >>> `SLOPE_SHIFT);
    acc = acc >>> `FRAC_SHIFT;
    if (acc < 0)
      acc = '0;
    return acc[`MAG_W-1:0];
  endfunction

  // per-channel rescale to the zone base
  for (genvar g = 0; g < `N_CH; g++)
  begin : g_ch
    logic signed [33:0] p_re;
    logic signed [33:0] p_im;
    assign p_re = $signed(ch_re[g]) * $signed({1'b0, st.scale[g]});
    assign p_im = $signed(ch_im[g]) * $signed({1'b0, st.scale[g]});
    assign sc_re[g] = {{2{p_re[33]}}, p_re[33:`FRAC_SHIFT]};
    assign sc_im[g] = {{2{p_im[33]}}, p_im[33:`FRAC_SHIFT]};
    assign sc_mag[g] = mag_fn(sc_re[g], sc_im[g]);
  end

  // dynamic replica: only connected channels enter the zone
  always_comb
  begin
    sum_re = '0;
    sum_im = '0;
    max_mag = '0;
    base_max = '0;
    ratio_err = 1'b0;
    for (int i = 0; i < `N_CH; i++)
    begin
      if (ch_status[i])
      begin
        sum_re = sum_re + sc_re[i];
        sum_im = sum_im + sc_im[i];
        if (sc_mag[i] > max_mag)
          max_mag = sc_mag[i];
      end
      if (st.primary[i] > base_max)
        base_max = st.primary[i];
    end
    for (int i = 0; i < `N_CH; i++)
    begin
      if (st.primary[i] == 16'h0000 || st.sec[i] == 3'h0)
        ratio_err = 1'b1;
      if ({st.primary[i], 5'h00} < {5'h00, base_max})
        ratio_err = 1'b1;
    end
  end

  assign chan_hit = addr[7:5] == `A_CHAN_PAGE && addr[1:0] == 2'h0
                    && 32'(addr[4:2]) < `N_CH;
  assign chan_idx = addr[4:2];

  always_comb
  begin
    if (st.fsm == zone_pkg::S_SPLINE)
    begin
      dv_num = st.restraint - st.knee_lo;
      dv_den = st.knee_hi - st.knee_lo;
    end
    else
    begin
      dv_num = {8'h00, st.primary[st.idx]};
      dv_den = `MAG_W'(st.base) * `MAG_W'(st.sec[st.idx]);
    end
  end

  always_comb
  begin
    unique case (addr)
      `A_CTRL:   rd_val = {31'h0, st.cfg_req};
      `A_STATUS: rd_val = {25'h0, st.region, st.overrun, st.flag,
                           st.fsm != zone_pkg::S_IDLE, st.cfg_error,
                           st.cfg_valid};
      `A_MIN_DIFF_THRESHOLD:   rd_val = {8'h00, st.min_diff_threshold};
      `A_SLOPE_LO: rd_val = {24'h0, st.slope_lo};
      `A_SLOPE_HI: rd_val = {24'h0, st.slope_hi};
      `A_KNEE_LO:  rd_val = {8'h00, st.knee_lo};
      `A_KNEE_HI:  rd_val = {8'h00, st.knee_hi};
      `A_BASE:     rd_val = {16'h0000, st.base};
      `A_DIFF:     rd_val = {8'h00, st.diff_mag};
      `A_REST:     rd_val = {8'h00, st.restraint};
      default:
      begin
        if (chan_hit)
          rd_val = {13'h0, st.sec[chan_idx], st.primary[chan_idx]};
        else
          rd_val = '0;
      end
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.result_valid = 1'b0;
    next_st.div_start = 1'b0;
    dm = mag_fn(st.diff_re, st.diff_im);
    bnd = '0;
    unique case (st.fsm)
      zone_pkg::S_IDLE:
      begin
        if (st.cfg_req)
        begin
          next_st.cfg_req = 1'b0;
          next_st.cfg_valid = 1'b0;
          next_st.base = base_max;
          next_st.cfg_error = ratio_err;
          next_st.idx = '0;
          next_st.div_start = 1'b1;
          next_st.fsm = zone_pkg::S_CFG;
        end
        else if (sample_valid && st.cfg_valid)
        begin
          next_st.diff_re = sum_re;
          next_st.diff_im = sum_im;
          next_st.restraint = max_mag;
          next_st.fsm = zone_pkg::S_EVAL;
        end
      end
      zone_pkg::S_CFG:
      begin
        if (dv_done)
        begin
          next_st.scale[st.idx] = (dv_quo > `ONE_PU_SCALE) ?
                                  `ONE_PU_SCALE : dv_quo;
          if (32'(st.idx) == `N_CH - 1)
          begin
            next_st.cfg_valid = !st.cfg_error;
            next_st.fsm = zone_pkg::S_IDLE;
          end
          else
          begin
            next_st.idx = st.idx + 3'h1;
            next_st.div_start = 1'b1;
          end
        end
      end
      zone_pkg::S_EVAL:
      begin
        if (st.restraint <= st.knee_lo)
        begin
          bnd = bias_fn(st.restraint, st.slope_lo);
          next_st.region = 2'h0;
          next_st.flag = dm > st.min_diff_threshold && dm > bnd;
          next_st.result_valid = 1'b1;
          next_st.fsm = zone_pkg::S_IDLE;
        end
        else if (st.restraint >= st.knee_hi)
        begin
          bnd = bias_fn(st.restraint, st.slope_hi);
          next_st.region = 2'h2;
          next_st.flag = dm > st.min_diff_threshold && dm > bnd;
          next_st.result_valid = 1'b1;
          next_st.fsm = zone_pkg::S_IDLE;
        end
        else
        begin
          next_st.region = 2'h1;
          next_st.div_start = 1'b1;
          next_st.fsm = zone_pkg::S_SPLINE;
        end
      end
      zone_pkg::S_SPLINE:
      begin
        if (dv_done)
        begin
          bnd = spline_fn(dv_quo[`SCALE_W-1:`QUO_TO_T], st.knee_lo,
                          st.knee_hi, st.slope_lo, st.slope_hi);
          next_st.flag = dm > st.min_diff_threshold && dm > bnd;
          next_st.result_valid = 1'b1;
          next_st.fsm = zone_pkg::S_IDLE;
        end
      end
    endcase

    if (wr_en)
    begin
      unique case (addr)
        `A_CTRL:
        begin
          if (wr_data[`CTRL_APPLY])
            next_st.cfg_req = 1'b1;
          if (wr_data[`CTRL_OVR_CLR])
            next_st.overrun = 1'b0;
        end
        `A_MIN_DIFF_THRESHOLD:   next_st.min_diff_threshold = wr_data[`MAG_W-1:0];
        `A_SLOPE_LO: next_st.slope_lo = wr_data[7:0];
        `A_SLOPE_HI: next_st.slope_hi = wr_data[7:0];
        `A_KNEE_LO:  next_st.knee_lo = wr_data[`MAG_W-1:0];
        `A_KNEE_HI:  next_st.knee_hi = wr_data[`MAG_W-1:0];
        default:
        begin
          if (chan_hit)
          begin
            next_st.primary[chan_idx] = wr_data[15:0];
            next_st.sec[chan_idx] = wr_data[18:16];
          end
        end
      endcase
    end

    // a sample arriving outside S_IDLE is flagged; setting wins over a same-cycle clear
    if (sample_valid && st.fsm != zone_pkg::S_IDLE)
      next_st.overrun = 1'b1;
    if (next_st.result_valid)
      next_st.diff_mag = dm;

    next_st.rd_data = rd_en ? rd_val : '0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= ZONE_RST;
    else
      st <= next_st;
  end

  zone_ratio_divider u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (st.div_start),
    .numer   (dv_num),
    .denom   (dv_den),
    .quo     (dv_quo),
    .done    (dv_done)
  );

  assign rd_data = st.rd_data;
  assign result_valid = st.result_valid;
  assign biased_diff_flag = st.flag;
  assign diff_mag = st.diff_mag;
  assign restraint_mag = st.restraint;
  assign cfg_ready = st.cfg_valid;

endmodule

// [dv/bus_zone_ratio_bias_logic_props.sv]
`timescale 1ns/10ps
`include "zone_defines.svh"
module zone_bias_props (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [7:0]             addr,
  input wire logic [31:0]            wr_data,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire logic [31:0]            rd_data,
  input wire logic                   sample_valid,
  input wire logic [`N_CH-1:0][15:0] ch_re,
  input wire logic [`N_CH-1:0][15:0] ch_im,
  input wire logic [`N_CH-1:0]       ch_status,
  input wire logic                   result_valid,
  input wire logic                   biased_diff_flag,
  input wire logic [`MAG_W-1:0]      diff_mag,
  input wire logic [`MAG_W-1:0]      restraint_mag,
  input wire logic                   cfg_ready
);
  logic [`MAG_W-1:0] min_diff_threshold;
  logic [`MAG_W-1:0] knee_lo;
  logic [`MAG_W-1:0] knee_hi;
  logic [7:0]        slope_lo;
  logic [7:0]        slope_hi;
  logic              apply_seen;
  // shadow of the characteristic settings as software writes them
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      min_diff_threshold <= `RST_MIN_DIFF_THRESHOLD;
      knee_lo <= `RST_KNEE_LO;
      knee_hi <= `RST_KNEE_HI;
      slope_lo <= `RST_SLOPE_LO;
      slope_hi <= `RST_SLOPE_HI;
      apply_seen <= 1'b0;
    end
    else
    begin
      if (wr_en && addr == `A_CTRL && wr_data[`CTRL_APPLY])
        apply_seen <= 1'b1;
      else if (!cfg_ready)
        apply_seen <= 1'b0;
      if (wr_en && addr == `A_MIN_DIFF_THRESHOLD)
        min_diff_threshold <= wr_data[`MAG_W-1:0];
      if (wr_en && addr == `A_KNEE_LO)
        knee_lo <= wr_data[`MAG_W-1:0];
      if (wr_en && addr == `A_KNEE_HI)
        knee_hi <= wr_data[`MAG_W-1:0];
      if (wr_en && addr == `A_SLOPE_LO)
        slope_lo <= wr_data[7:0];
      if (wr_en && addr == `A_SLOPE_HI)
        slope_hi <= wr_data[7:0];
    end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  rd_idle_zero_a: assert property (
    !$past(rd_en) |-> rd_data == 32'h0) else $error("rd_data not idle");
  rd_unmapped_a: assert property (
    $past(rd_en && addr > `A_REST && addr < 8'h40) |-> rd_data == 32'h0)
    else $error("unmapped read not zero");
  result_one_a: assert property (
    result_valid |=> !result_valid) else $error("result pulse too long");
  result_bound_a: assert property (
    sample_valid && cfg_ready |-> ##[2:24] result_valid)
    else $error("sample gave no result");
  no_cfg_result_a: assert property (
    !cfg_ready [*3] |-> !result_valid) else $error("result unconfigured");
  cfg_drop_a: assert property (
    $fell(cfg_ready) |-> apply_seen) else $error("config lost by itself");
  flag_hold_a: assert property (
    !result_valid |-> $stable(biased_diff_flag) && $stable(diff_mag))
    else $error("outputs moved between results");
  flag_min_diff_threshold_a: assert property (
    result_valid && biased_diff_flag |-> diff_mag > min_diff_threshold)
    else $error("flag below min_diff_threshold");
  flag_low_a: assert property (
    result_valid && restraint_mag <= knee_lo && diff_mag > min_diff_threshold
    |-> biased_diff_flag == (40'(diff_mag) * 40'h100 > 40'(restraint_mag)
    * slope_lo)) else $error("low slope boundary wrong");
  flag_high_a: assert property (
    result_valid && restraint_mag >= knee_hi && biased_diff_flag
    |-> 40'(diff_mag) * 40'h100 + 40'h100 > 40'(restraint_mag) * slope_hi)
    else $error("high slope boundary wrong");

  cover property (result_valid && biased_diff_flag);
  cover property (result_valid && !biased_diff_flag && diff_mag > min_diff_threshold);
  cover property (result_valid && restraint_mag > knee_lo
    && restraint_mag < knee_hi);
  cover property ($rose(cfg_ready));
endmodule

bind bus_zone_ratio_bias_logic zone_bias_props i_props (.clk(clk),
  .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .sample_valid(sample_valid),
  .ch_re(ch_re), .ch_im(ch_im), .ch_status(ch_status),
  .result_valid(result_valid), .biased_diff_flag(biased_diff_flag),
  .diff_mag(diff_mag), .restraint_mag(restraint_mag),
  .cfg_ready(cfg_ready));

// [dv/ct_source_model.sv]
`timescale 1ns/10ps
`include "zone_defines.svh"
module ct_source_model #(
  parameter logic [`N_CH-1:0] FIXED_MASK = 6'h01
) (
  input  wire logic                   clk,
  output logic                        sample_valid,
  output logic [`N_CH-1:0][15:0]      ch_re,
  output logic [`N_CH-1:0][15:0]      ch_im,
  output logic [`N_CH-1:0]            ch_status
);
  logic [`N_CH-1:0] contact;
  initial
  begin
    sample_valid = 1'b0;
    ch_re = '0;
    ch_im = '0;
    contact = '0;
  end
  // circuits wired only to this bus read as always connected
  assign ch_status = contact | FIXED_MASK;
  task automatic send(input logic [`N_CH-1:0][15:0] r,
                      input logic [`N_CH-1:0][15:0] i,
                      input logic [`N_CH-1:0]       s);
    @(posedge clk);
    sample_valid <= 1'b1;
    ch_re <= r;
    ch_im <= i;
    contact <= s;
    @(posedge clk);
    sample_valid <= 1'b0;
    // phasor lines carry no stale sample afterwards
    ch_re <= ~r;
    ch_im <= ~i;
  endtask
endmodule

// [dv/bus_zone_ratio_bias_logic_tb.sv]
`timescale 1ns/10ps
`include "zone_defines.svh"
module bus_zone_ratio_bias_logic_tb;
  logic                   clk;
  logic                   reset_n;
  logic                   wr_en;
  logic                   rd_en;
  logic [7:0]             addr;
  logic [31:0]            wr_data;
  logic [31:0]            rd_data;
  logic                   sample_valid;
  logic [`N_CH-1:0][15:0] ch_re;
  logic [`N_CH-1:0][15:0] ch_im;
  logic [`N_CH-1:0]       ch_status;
  logic                   result_valid;
  logic                   biased_diff_flag;
  logic [`MAG_W-1:0]      diff_mag;
  logic [`MAG_W-1:0]      restraint_mag;
  logic                   cfg_ready;
  logic [`N_CH-1:0][15:0] re;
  logic [`N_CH-1:0][15:0] im;
  logic [`N_CH-1:0]       st;
  logic                   seen;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer seed = 90034;
  integer prim [`N_CH] = '{600, 500, 600, 1000, 500, 600};
  integer sec [`N_CH] = '{5, 1, 5, 5, 1, 5};
  integer base = 1000;
  integer min_diff_threshold = `RST_MIN_DIFF_THRESHOLD;
  integer slo = `RST_SLOPE_LO;
  integer shi = `RST_SLOPE_HI;
  integer klo = `RST_KNEE_LO;
  integer khi = `RST_KNEE_HI;
  logic [7:0] dflt_a [8] = '{`A_MIN_DIFF_THRESHOLD, `A_SLOPE_LO, `A_SLOPE_HI,
    `A_KNEE_LO, `A_KNEE_HI, `A_STATUS, `A_BASE, 8'h30};
  integer dflt_v [8] = '{`RST_MIN_DIFF_THRESHOLD, `RST_SLOPE_LO, `RST_SLOPE_HI,
    `RST_KNEE_LO, `RST_KNEE_HI, 0, 0, 0};

  bus_zone_ratio_bias_logic i_dut (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .sample_valid(sample_valid), .ch_re(ch_re),
    .ch_im(ch_im), .ch_status(ch_status), .result_valid(result_valid),
    .biased_diff_flag(biased_diff_flag), .diff_mag(diff_mag),
    .restraint_mag(restraint_mag), .cfg_ready(cfg_ready));
  ct_source_model #(.FIXED_MASK(6'h01)) i_src (.clk(clk),
    .sample_valid(sample_valid), .ch_re(ch_re), .ch_im(ch_im),
    .ch_status(ch_status));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task automatic check(input string what, input integer exp,
                       input logic [31:0] got, input integer tol);
    cmp_count = cmp_count + 1;
    if ($isunknown(got) || got + tol < exp || got > exp + tol)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input integer exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check($sformatf("reg %0h", a), exp, rd_data, 0);
  endtask

  task automatic configure(input logic ok);
    for (int g = 0; g < `N_CH; g++)
      wr(8'h40 + 8'(4 * g), {13'h0, 3'(sec[g]), 16'(prim[g])});
    wr(`A_CTRL, 32'h1);
    // an earlier valid configuration reads ready until the apply is taken
    repeat (2) @(negedge clk);
    for (int n = 0; n < 400 && cfg_ready !== 1'b1; n++)
      @(negedge clk);
    check("cfg_ready", ok, cfg_ready, 0);
  endtask

  task automatic fire();
    i_src.send(re, im, st);
    seen = 1'b0;
    for (int n = 0; n < 30 && seen !== 1'b1; n++)
    begin
      @(negedge clk);
      seen = result_valid;
    end
  endtask

  function automatic integer est(input integer a, input integer b);
    integer x;
    integer y;
    x = (a < 0) ? -a : a;
    y = (b < 0) ? -b : b;
    if (y > x)
      est = (y * 7 / 8 + x / 2 > y) ? y * 7 / 8 + x / 2 : y;
    else
      est = (x * 7 / 8 + y / 2 > x) ? x * 7 / 8 + y / 2 : x;
  endfunction

  task automatic sample();
    integer dre;
    integer dim;
    integer r;
    integer pr;
    integer pi;
    integer d;
    integer lo;
    integer hi;
    integer t;
    dre = 0;
    dim = 0;
    r = 0;
    for (int g = 0; g < `N_CH; g++)
      if (st[g] || g == 0)
      begin
        pr = $signed(re[g]) * prim[g] * 16 / (sec[g] * base);
        pi = $signed(im[g]) * prim[g] * 16 / (sec[g] * base);
        dre = dre + pr;
        dim = dim + pi;
        if (est(pr, pi) > r)
          r = est(pr, pi);
      end
    d = est(dre, dim);
    fire();
    check("result", 1, seen, 0);
    check("diff", d, diff_mag, d / 32 + 24);
    check("restraint", r, restraint_mag, r / 32 + 24);
    t = (d + r) / 16 + 48;
    lo = r * slo / 256;
    hi = r * shi / 256;
    if (r <= klo)
      hi = lo;
    else if (r >= khi)
      lo = hi;
    if (d > min_diff_threshold + t && d > hi + t)
      check("flag", 1, biased_diff_flag, 0);
    else if (d + t < min_diff_threshold || d + t < lo)
      check("flag", 0, biased_diff_flag, 0);
  endtask

  initial
  begin
    reset_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    re = '0;
    im = '0;
    st = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 8; k++)
      rdchk(dflt_a[k], dflt_v[k]);
    prim[0] = 31;
    configure(1'b0);
    rdchk(`A_STATUS, 2);
    fire();
    check("refused", 0, seen, 0);
    prim[0] = 32;
    configure(1'b1);
    sample();
    prim[0] = 600;
    configure(1'b1);
    rdchk(`A_BASE, 1000);
    for (int k = 0; k < 2; k++)
    begin
      st = 6'h02;
      re[0] = k ? 16'h10AB : 16'h0855;
      re[1] = k ? 16'h0200 : 16'h0400;
      sample();
      check("diff_3pu", 32'h3000, diff_mag, 64);
    end
    for (int i = 0; i < 48; i++)
    begin
      if (i == 24)
      begin
        min_diff_threshold = 24'h001800;
        slo = 8'h20;
        shi = 8'hC0;
        klo = 24'h004000;
        khi = 24'h00C000;
        wr(`A_MIN_DIFF_THRESHOLD, min_diff_threshold);
        wr(`A_SLOPE_LO, slo);
        wr(`A_SLOPE_HI, shi);
        wr(`A_KNEE_LO, klo);
        wr(`A_KNEE_HI, khi);
      end
      st = 6'($random(seed));
      for (int g = 0; g < `N_CH; g++)
      begin
        re[g] = 16'($random(seed) % 12000);
        im[g] = 16'($random(seed) % 12000);
      end
      if (i % 2)
      begin
        st = 6'h24;
        re[2] = -(re[0] + re[5]) + 16'($random(seed) % 64);
        im[2] = -(im[0] + im[5]) + 16'($random(seed) % 64);
      end
      sample();
    end
    // spline sample, then one sent while busy: dropped, overrun set
    re = '0;
    im = '0;
    re[0] = 16'h3200;
    i_src.send(re, im, 6'h00);
    i_src.send(re, im, 6'h00);
    repeat (30) @(posedge clk);
    rdchk(`A_STATUS, 57);
    wr(`A_CTRL, 32'h2);
    rdchk(`A_STATUS, 41);
    rdchk(`A_BASE, 1000);
    give_verdict();
  end
endmodule
